// ### rtl/adc_ctrl_params.svh
/*
 * Offsets, field positions and counts for the conversion control block.
 * Assumes inclusion by bare name from the design module and the testbench.
 */
`ifndef ADC_CTRL_PARAMS_SVH
`define ADC_CTRL_PARAMS_SVH
`define OFS_CTRL0 8'h00
`define OFS_CTRL1 8'h04
`define OFS_CTRL2 8'h08
`define OFS_RES_HI 8'h0C
`define OFS_RES_LO 8'h10
`define OFS_IRQ 8'h14
`define C0_EN 0
`define C0_GO 1
`define C0_CHS_LO 2
`define C0_CHS_HI 6
`define C0_RMD 7
`define C1_PREF_LO 0
`define C1_PREF_HI 1
`define C1_NREF 2
`define C1_CS_LO 4
`define C1_CS_HI 6
`define C1_FMT 7
`define C2_CHSN_LO 0
`define C2_CHSN_HI 3
`define C2_TRIG_LO 4
`define C2_TRIG_HI 7
`define IRQ_FLAG 0
`define IRQ_EN 1
`define REG_RST 8'h00
`define CONV_TADS 4'hF
`define INSTR_CLKS 3'h4
`define TRIG_RSVD 4'h3
`define TRIG_FIRST_PWM 4'h4
`define TRIG_LAST_PWM 4'hF
`define TRIG_GAP_LO 4'hA
`define TRIG_GAP_HI 4'hC
`endif

// ### rtl/adc_ctrl_pkg.sv
/*
 * Types for the conversion control block.
 * Assumes adc_ctrl_params.svh is on the include path.
 */
package adc_ctrl_pkg;
  typedef enum logic [1:0] {ST_IDLE, ST_DELAY, ST_CONV} conv_state_t;
  typedef struct packed {
    logic sign;
    logic [11:0] mag;
  } core_result_t;
  typedef struct packed {
    logic power;
    logic start;
    logic abort;
    logic tick;
  } core_ctrl_t;
endpackage

// ### rtl/adc_conversion_control.sv
/*
 * Conversion control around a 12-bit differential converter core: start,
 * completion, abort, done flag, sleep handling, auto trigger, result format.
 * Assumes an APB master on mclk, a converter core that presents its result
 * when the fifteenth conversion-clock tick is counted, and trigger and
 * internal-oscillator inputs that may be asynchronous to mclk.
 */
`include "adc_ctrl_params.svh"

module adc_conversion_control (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic sleep_active,
  input wire logic frc_clk_in,
  input wire logic [15:0] trigger_events,
  input wire adc_ctrl_pkg::core_result_t core_result,
  output adc_ctrl_pkg::core_ctrl_t core_ctrl,
  output logic [4:0] pos_channel,
  output logic [3:0] neg_channel,
  output logic [2:0] ref_select,
  output logic conv_irq,
  output logic wake_req
);
  import adc_ctrl_pkg::*;

  // divider ratio minus one for the system-clock conversion clocks
  function automatic logic [5:0] div_last(input logic [2:0] cs);
    case (cs)
      3'h0: div_last = 6'h01;
      3'h4: div_last = 6'h03;
      3'h1: div_last = 6'h07;
      3'h5: div_last = 6'h0F;
      3'h2: div_last = 6'h1F;
      3'h6: div_last = 6'h3F;
      default: div_last = 6'h01;
    endcase
  endfunction

  function automatic logic trig_valid(input logic [3:0] sel);
    trig_valid = (sel != 4'h0) && (sel != `TRIG_RSVD)
      && !((sel >= `TRIG_GAP_LO) && (sel <= `TRIG_GAP_HI));
  endfunction

  logic [7:0] ctrl0_r;
  logic [7:0] ctrl1_r;
  logic [7:0] ctrl2_r;
  logic [7:0] res_hi_r;
  logic [7:0] res_lo_r;
  logic flag_r;
  logic irq_en_r;
  logic pwr_off_r;
  conv_state_t state_r;
  conv_state_t state_nxt;
  logic [5:0] div_r;
  logic [3:0] tad_r;
  logic [2:0] dly_r;
  logic [1:0] frc_sync_r;
  logic frc_prev_r;
  logic [15:0] trig_s1_r;
  logic [15:0] trig_s2_r;
  logic trig_prev_r;
  logic [31:0] prdata_r;

  // bus decode
  wire setup_ph = psel && !penable;
  wire wr_acc = psel && penable && pwrite;
  wire hit_c0 = paddr == `OFS_CTRL0;
  wire hit_c1 = paddr == `OFS_CTRL1;
  wire hit_c2 = paddr == `OFS_CTRL2;
  wire hit_hi = paddr == `OFS_RES_HI;
  wire hit_lo = paddr == `OFS_RES_LO;
  wire hit_irq = paddr == `OFS_IRQ;
  wire mapped = hit_c0 || hit_c1 || hit_c2 || hit_hi || hit_lo || hit_irq;
  wire wr_c0 = wr_acc && hit_c0;
  wire wr_c1 = wr_acc && hit_c1;
  wire wr_c2 = wr_acc && hit_c2;
  wire wr_hi = wr_acc && hit_hi;
  wire wr_lo = wr_acc && hit_lo;
  wire wr_irq = wr_acc && hit_irq;

  // control fields
  wire enable = ctrl0_r[`C0_EN];
  wire busy = ctrl0_r[`C0_GO];
  wire result_width_mode = ctrl0_r[`C0_RMD];
  wire result_format_select = ctrl1_r[`C1_FMT];
  wire [2:0] conv_clock_select = ctrl1_r[`C1_CS_HI:`C1_CS_LO];
  wire [3:0] trigger_source_select = ctrl2_r[`C2_TRIG_HI:`C2_TRIG_LO];
  wire frc_sel = conv_clock_select[1:0] == 2'b11;

  // conversion clock ticks
  wire frc_tick = frc_sync_r[1] && !frc_prev_r;
  wire div_tick = div_r == div_last(conv_clock_select);
  wire conv_tick = frc_sel ? frc_tick : div_tick;

  // trigger select and edge
  wire trig_sel_lvl = trig_valid(trigger_source_select)
    && trig_s2_r[trigger_source_select];
  wire trig_pulse = trig_sel_lvl && !trig_prev_r;

  // sleep, start, completion and abort decisions
  wire sleep_abort = sleep_active && !frc_sel;
  wire sw_go_set = wr_c0 && pwdata[`C0_GO] && !busy;
  wire sw_go_clr = wr_c0 && !pwdata[`C0_GO] && busy;
  wire hw_go_set = trig_pulse && !busy;
  wire go_set = (sw_go_set || hw_go_set) && enable && !pwr_off_r && !sleep_abort;
  wire conv_end = (state_r == ST_CONV) && conv_tick && (tad_r == `CONV_TADS - 4'h1);
  wire abort = busy && (sw_go_clr || sleep_abort || !enable);

  // result formatting
  wire [11:0] mag = result_width_mode ? {2'b00, core_result.mag[11:2]}
    : core_result.mag;
  wire [15:0] mag_ext = {4'h0, mag};
  wire [15:0] tc_val = core_result.sign ? (16'h0000 - mag_ext) : mag_ext;
  wire [15:0] sm_val = result_width_mode
    ? {core_result.mag[11:2], 5'h00, core_result.sign}
    : {core_result.mag, 3'h0, core_result.sign};
  wire [15:0] res_val = result_format_select ? tc_val : sm_val;

  // read mux
  wire [7:0] irq_rd = {6'h00, irq_en_r, flag_r};
  wire [7:0] rd_byte = hit_c0 ? ctrl0_r
    : hit_c1 ? {ctrl1_r[7:4], 1'b0, ctrl1_r[2:0]}
    : hit_c2 ? ctrl2_r
    : hit_hi ? res_hi_r
    : hit_lo ? res_lo_r
    : hit_irq ? irq_rd
    : 8'h00;

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      ST_IDLE: begin
        if (go_set) begin
          state_nxt = frc_sel ? ST_DELAY : ST_CONV;
        end
      end
      ST_DELAY: begin
        if (abort) begin
          state_nxt = ST_IDLE;
        end else if (dly_r == `INSTR_CLKS - 3'h1) begin
          state_nxt = ST_CONV;
        end
      end
      ST_CONV: begin
        if (abort || conv_end) begin
          state_nxt = ST_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      state_r <= ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // delay and conversion counters
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      dly_r <= 3'h0;
      tad_r <= 4'h0;
      div_r <= 6'h00;
    end else begin
      dly_r <= (state_r == ST_DELAY) ? dly_r + 3'h1 : 3'h0;
      div_r <= div_tick ? 6'h00 : div_r + 6'h01;
      if (state_r != ST_CONV) begin
        tad_r <= 4'h0;
      end else if (conv_tick) begin
        tad_r <= tad_r + 4'h1;
      end
    end
  end

  // synchronisers
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      frc_sync_r <= 2'b00;
      frc_prev_r <= 1'b0;
      trig_s1_r <= 16'h0000;
      trig_s2_r <= 16'h0000;
      trig_prev_r <= 1'b0;
    end else begin
      frc_sync_r <= {frc_sync_r[0], frc_clk_in};
      frc_prev_r <= frc_sync_r[1];
      trig_s1_r <= trigger_events;
      trig_s2_r <= trig_s1_r;
      trig_prev_r <= trig_sel_lvl;
    end
  end

  // control registers
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl0_r <= `REG_RST;
      ctrl1_r <= `REG_RST;
      ctrl2_r <= `REG_RST;
    end else begin
      if (wr_c0) begin
        ctrl0_r <= pwdata[7:0];
      end
      if (go_set) begin
        ctrl0_r[`C0_GO] <= 1'b1;
      end else if (conv_end || abort || (wr_c0 && pwdata[`C0_GO] && !busy)) begin
        ctrl0_r[`C0_GO] <= 1'b0;
      end
      if (wr_c1) begin
        ctrl1_r <= pwdata[7:0];
      end
      if (wr_c2) begin
        ctrl2_r <= pwdata[7:0];
      end
    end
  end

  // result pair
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      res_hi_r <= `REG_RST;
      res_lo_r <= `REG_RST;
    end else if (conv_end && !abort) begin
      res_hi_r <= res_val[15:8];
      res_lo_r <= res_val[7:0];
    end else if (go_set) begin
      res_hi_r <= 8'h00;
      res_lo_r <= 8'h00;
    end else begin
      if (wr_hi) begin
        res_hi_r <= pwdata[7:0];
      end
      if (wr_lo) begin
        res_lo_r <= pwdata[7:0];
      end
    end
  end

  // done flag, enable, sleep power-down
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      flag_r <= 1'b0;
      irq_en_r <= 1'b0;
      pwr_off_r <= 1'b0;
    end else begin
      if (conv_end && !abort) begin
        flag_r <= 1'b1;
      end else if (wr_irq) begin
        flag_r <= pwdata[`IRQ_FLAG];
      end
      if (wr_irq) begin
        irq_en_r <= pwdata[`IRQ_EN];
      end
      if (!sleep_active) begin
        pwr_off_r <= 1'b0;
      end else if ((conv_end && !irq_en_r) || sleep_abort) begin
        pwr_off_r <= 1'b1;
      end
    end
  end

  // bus read data, taken at setup
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      prdata_r <= 32'h0000_0000;
    end else if (setup_ph) begin
      prdata_r <= {24'h00_0000, rd_byte};
    end
  end

  assign prdata = prdata_r;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;

  assign core_ctrl.power = enable && !pwr_off_r && !sleep_abort;
  assign core_ctrl.start = (state_r != ST_CONV) && (state_nxt == ST_CONV);
  assign core_ctrl.abort = abort && (state_r == ST_CONV);
  assign core_ctrl.tick = (state_r == ST_CONV) && conv_tick && !abort;
  assign pos_channel = ctrl0_r[`C0_CHS_HI:`C0_CHS_LO];
  assign neg_channel = ctrl2_r[`C2_CHSN_HI:`C2_CHSN_LO];
  assign ref_select = {ctrl1_r[`C1_NREF], ctrl1_r[`C1_PREF_HI:`C1_PREF_LO]};
  assign conv_irq = flag_r && irq_en_r;
  assign wake_req = sleep_active && flag_r && irq_en_r;
endmodule

// ### tb/adc_core_model.sv
/* behavioural converter core: presents a result once the last tick arrives.
   assumes the control block drives power, start and tick on mclk. */
module adc_core_model (
  input wire logic mclk,
  input wire adc_ctrl_pkg::core_ctrl_t core_ctrl,
  input wire adc_ctrl_pkg::core_result_t val,
  output adc_ctrl_pkg::core_result_t core_result
);
  timeunit 1ns;
  timeprecision 1ns;
  import adc_ctrl_pkg::*;
  logic [3:0] ticks_r;
  // result only valid from the fourteenth tick on while powered, junk otherwise
  assign core_result = (core_ctrl.power && ticks_r >= 4'hE) ? val : ~val;
  always_ff @(posedge mclk) begin
    if (core_ctrl.start)
      ticks_r <= 4'h0;
    else if (core_ctrl.tick)
      ticks_r <= ticks_r + 4'h1;
  end
endmodule

// ### tb/adc_ctrl_monitor.sv
/* checker on the ports of the conversion control block.
   assumes binding to adc_conversion_control. */
module adc_ctrl_monitor (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic pslverr,
  input wire logic sleep_active,
  input wire adc_ctrl_pkg::core_ctrl_t core_ctrl,
  input wire logic conv_irq,
  input wire logic wake_req
);
  timeunit 1ns;
  timeprecision 1ns;
  import adc_ctrl_pkg::*;
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_b);
  sequence s_start_once;
    core_ctrl.start ##1 !core_ctrl.start;
  endsequence
  sequence s_abort_once;
    core_ctrl.abort ##1 !core_ctrl.abort;
  endsequence
  a_wake_follows: assert property (
    wake_req == (sleep_active && conv_irq)) else $error("wake request wrong");
  a_irq_cause: assert property (
    $rose(conv_irq) |-> $past(core_ctrl.tick || (psel && penable && pwrite)))
    else $error("interrupt rose without cause");
  a_start_pulse: assert property (
    core_ctrl.start |-> s_start_once) else $error("start not a lone pulse");
  a_abort_pulse: assert property (
    core_ctrl.abort |-> s_abort_once) else $error("abort not a pulse");
  a_tick_powered: assert property (
    core_ctrl.tick |-> core_ctrl.power) else $error("tick while powered down");
  a_start_powered: assert property (
    core_ctrl.start |-> core_ctrl.power && !core_ctrl.abort) else $error("bad start");
  a_slverr_access: assert property (
    pslverr |-> psel && penable) else $error("slave error outside access");
  a_reset_quiet: assert property (
    $rose(rst_b) |-> core_ctrl == 4'h0 && !conv_irq) else $error("not idle at reset");
endmodule

bind adc_conversion_control adc_ctrl_monitor mon (.mclk, .rst_b, .psel, .penable,
  .pwrite, .pslverr, .sleep_active, .core_ctrl, .conv_irq, .wake_req);

// ### tb/adc_conversion_control_tb.sv
/* self-checking bench: apb master, core model, format and sleep tests.
   assumes rtl header, package and design compiled first. */
`include "adc_ctrl_params.svh"
module adc_conversion_control_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import adc_ctrl_pkg::*;
  logic mclk = 0, rst_b = 0, psel = 0, penable = 0, pwrite = 0, slp = 0, frc = 0;
  logic [7:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, q;
  logic pready, pslverr, err, conv_irq, wake_req;
  logic [15:0] trig = 0;
  logic [4:0] pos_channel;
  logic [3:0] neg_channel;
  logic [2:0] ref_select;
  core_result_t core_result, val = 0;
  core_ctrl_t core_ctrl;
  int mismatches = 0, n_tests = 0, cyc = 0;
  always #10 mclk = ~mclk;
  always #35 frc = ~frc;
  adc_conversion_control dut (.mclk, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .sleep_active(slp), .frc_clk_in(frc),
    .trigger_events(trig), .core_result, .core_ctrl, .pos_channel, .neg_channel,
    .ref_select, .conv_irq, .wake_req);
  adc_core_model core (.mclk, .core_ctrl, .val, .core_result);
  task test_done;
    $display("tests %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 30000) begin
      mismatches++;
      test_done();
    end
  end
  task chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1;
    do @(posedge mclk); while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task tick(input int n);
    repeat (n) @(posedge mclk);
  endtask
  function automatic logic [15:0] fexp(logic f, r, s, logic [11:0] m);
    logic [15:0] v;
    v = r ? {6'h0, m[11:2]} : {4'h0, m};
    if (!f)
      return r ? {m[11:2], 5'h0, s} : {m, 3'h0, s};
    return s ? 16'h0000 - v : v;
  endfunction
  task conv(input logic [2:0] cs, input logic f, r, s, input logic [11:0] m);
    logic [15:0] e;
    e = fexp(f, r, s, m);
    val <= {s, m};
    apb(1, `OFS_CTRL1, {f, cs, 4'h0});
    apb(1, `OFS_CTRL0, {r, 7'h01});
    apb(1, `OFS_CTRL0, {r, 7'h03});
    apb(0, `OFS_RES_LO, 0);
    chk(q, 0);
    for (int i = 0; i < 400; i++) begin
      apb(0, `OFS_CTRL0, 0);
      if (q[1] === 1'b0)
        break;
    end
    chk(q, {r, 7'h01});
    apb(0, `OFS_RES_HI, 0);
    chk(q, e[15:8]);
    apb(0, `OFS_RES_LO, 0);
    chk(q, e[7:0]);
    apb(0, `OFS_IRQ, 0);
    chk(q[0], 1);
    chk(conv_irq, q[1]);
    apb(1, `OFS_IRQ, {30'h0, q[1], 1'b0});
    apb(0, `OFS_IRQ, 0);
    chk(q[0], 0);
    chk(conv_irq, 0);
  endtask
  task t_regs;
    for (int a = 0; a <= 24; a += 4) begin
      apb(0, a[7:0], 0);
      chk(q, 0);
      chk(err, a == 24);
    end
    apb(1, `OFS_CTRL0, 8'h54);
    apb(1, `OFS_CTRL1, 8'h0D);
    apb(1, `OFS_CTRL2, 8'h09);
    tick(1);
    chk(pos_channel, 5'h15);
    chk(ref_select, 3'h5);
    chk(neg_channel, 4'h9);
    apb(0, `OFS_CTRL1, 0);
    chk(q, 8'h05);
    apb(1, `OFS_CTRL0, 0);
    apb(1, `OFS_CTRL1, 0);
    apb(1, `OFS_CTRL2, 0);
    $display("regs done");
  endtask
  task t_fmt;
    logic [2:0] cs[8];
    cs = '{3'h0, 3'h4, 3'h1, 3'h5, 3'h2, 3'h6, 3'h3, 3'h7};
    for (int i = 0; i < 8; i++)
      conv(cs[i], i[0], i[1], i[2], i[2] ? 12'hFFF : 12'h933);
    apb(1, `OFS_IRQ, 2);
    conv(0, 1, 0, 1, 12'h001);
    apb(1, `OFS_IRQ, 0);
    $display("format done");
  endtask
  task t_trig;
    apb(1, `OFS_CTRL1, 0);
    for (int c = 0; c < 16; c++) begin
      apb(1, `OFS_CTRL2, {c[3:0], 4'h0});
      trig <= 16'h0001 << c;
      tick(8);
      trig <= 0;
      tick(60);
      apb(0, `OFS_IRQ, 0);
      chk(q[0], c inside {1, 2, [4:9], [13:15]});
      apb(1, `OFS_IRQ, 0);
    end
    apb(1, `OFS_CTRL2, 0);
    $display("trigger done");
  endtask
  task t_abort;
    apb(1, `OFS_CTRL1, 8'h60);
    apb(1, `OFS_CTRL0, 3);
    tick(100);
    apb(1, `OFS_CTRL0, 1);
    tick(1000);
    apb(0, `OFS_RES_HI, 0);
    chk(q, 0);
    apb(0, `OFS_RES_LO, 0);
    chk(q, 0);
    apb(0, `OFS_IRQ, 0);
    chk(q[0], 0);
    $display("abort done");
  endtask
  task t_sleep;
    int n;
    apb(1, `OFS_IRQ, 2);
    apb(1, `OFS_CTRL1, 8'h70);
    apb(1, `OFS_CTRL0, 3);
    slp <= 1;
    n = 0;
    while (core_ctrl.start !== 1'b1 && n < 20) begin
      tick(1);
      n++;
    end
    chk(n, `INSTR_CLKS);
    for (int i = 0; i < 300 && wake_req !== 1'b1; i++)
      tick(1);
    chk(wake_req, 1);
    slp <= 0;
    apb(1, `OFS_IRQ, 0);
    apb(1, `OFS_CTRL0, 3);
    slp <= 1;
    tick(300);
    chk(core_ctrl.power, 0);
    apb(0, `OFS_CTRL0, 0);
    chk(q, 1);
    slp <= 0;
    apb(1, `OFS_IRQ, 0);
    apb(1, `OFS_CTRL1, 8'h60);
    apb(1, `OFS_CTRL0, 3);
    tick(50);
    slp <= 1;
    tick(5);
    chk(core_ctrl.power, 0);
    apb(0, `OFS_CTRL0, 0);
    chk(q, 1);
    tick(1000);
    apb(0, `OFS_IRQ, 0);
    chk(q[0], 0);
    slp <= 0;
    $display("sleep done");
  endtask
  task t_reset;
    apb(1, `OFS_CTRL0, 3);
    tick(20);
    rst_b <= 0;
    tick(8);
    rst_b <= 1;
    apb(0, `OFS_CTRL0, 0);
    chk(q, 0);
    chk(core_ctrl, 0);
    $display("reset done");
  endtask
  initial begin
    tick(8);
    rst_b <= 1;
    t_regs();
    t_fmt();
    t_trig();
    t_abort();
    t_sleep();
    t_reset();
    test_done();
  end
endmodule
